// file: urx_defs.vh
`ifndef URX_DEFS_VH
`define URX_DEFS_VH

// register addresses
`define URX_ADDR_STA 3'h0
`define URX_ADDR_CTB 3'h1
`define URX_ADDR_CFC 3'h2
`define URX_ADDR_DAT 3'h3
`define URX_ADDR_BAUD 3'h4

// status_register_a bits
`define URX_STA_RXC 7
`define URX_STA_FE 4
`define URX_STA_DOR 3
`define URX_STA_PE 2
`define URX_STA_DSPD 1

// control_register_b bits
`define URX_CTB_RECEIVE_COMPLETE_IRQ_ENABLE 7
`define URX_CTB_RECEIVE_ENABLE_BIT 4
`define URX_CTB_SZ2 2
`define URX_CTB_RX9 1
`define URX_CTB_TX9 0

// frame_config_register_c bits
`define URX_CFC_MODE_HI 7
`define URX_CFC_MODE_LO 6
`define URX_CFC_UPM1 5
`define URX_CFC_UPM0 4
`define URX_CFC_SBS 3
`define URX_CFC_SZ1 2
`define URX_CFC_SZ0 1

`define URX_MODE_SYNC 2'h1
`define URX_SZ_NINE 3'h7
`define URX_SZ_BASE 4'h5
`define URX_SZ_EIGHT 4'h8
`define URX_SZ_NINE_BITS 4'h9

// majority samples and bit length, normal and double speed
`define URX_N_V1 5'h08
`define URX_N_V2 5'h09
`define URX_N_V3 5'h0A
`define URX_N_LAST 5'h10
`define URX_D_V1 5'h04
`define URX_D_V2 5'h05
`define URX_D_V3 5'h06
`define URX_D_LAST 5'h08
`define URX_SAMP_FIRST 5'h01

// receive buffer entry fields
`define URX_ENT_PE 0
`define URX_ENT_DOR 1
`define URX_ENT_FE 2
`define URX_ENT_DLO 3
`define URX_ENT_DHI 10
`define URX_ENT_B8 11

// reset values
`define URX_RST_STA 1'b0
`define URX_RST_CTB 8'h00
`define URX_RST_CFC 8'h06
`define URX_RST_BAUD 8'h00

`endif

// file: urx_receiver.v
`timescale 1ns/1ps
`include "urx_defs.vh"

module urx_receiver #(
    parameter DEPTH = 2,
    parameter PTR_W = 1,
    parameter BAUD_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata_reg,
    input wire serial_input_pin,
    input wire transfer_clock_pin,
    output reg pin_override_reg,
    output reg rx_complete_irq_reg
);

    localparam ST_IDLE = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_DATA = 3'd2;
    localparam ST_PAR = 3'd3;
    localparam ST_STOP = 3'd4;
    localparam [PTR_W:0] CNT_ONE = {{PTR_W{1'b0}}, 1'b1};
    localparam [PTR_W:0] CNT_FULL = DEPTH;

    // software visible control
    reg double_speed_reg;
    reg rx_irq_en_reg;
    reg receive_enable_bit_reg;
    reg size_hi_reg;
    reg transmit_ninth_bit_reg;
    reg [7:0] cfg_c_reg;
    reg [BAUD_W-1:0] baud_reg;

    // receive path
    reg [2:0] state_reg;
    reg [BAUD_W-1:0] presc_reg;
    reg [4:0] samp_reg;
    reg [1:0] vote_reg;
    reg [3:0] bit_cnt_reg;
    reg [8:0] shift_reg;
    reg par_acc_reg;
    reg par_err_reg;
    reg xck_prev_reg;

    // completed frame waiting for a free buffer slot
    reg pend_valid_reg;
    reg [8:0] pend_data_reg;
    reg pend_fe_reg;
    reg pend_pe_reg;
    reg overrun_reg;

    // receive buffer
    reg [11:0] fifo_mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr_reg;
    reg [PTR_W-1:0] rd_ptr_reg;
    reg [PTR_W:0] count_reg;

    wire [1:0] mode = {cfg_c_reg[`URX_CFC_MODE_HI],
                       cfg_c_reg[`URX_CFC_MODE_LO]};
    wire sync_mode = (mode == `URX_MODE_SYNC);
    wire par_on = cfg_c_reg[`URX_CFC_UPM1];
    wire par_odd = cfg_c_reg[`URX_CFC_UPM0];
    wire [2:0] size = {size_hi_reg, cfg_c_reg[`URX_CFC_SZ1],
                       cfg_c_reg[`URX_CFC_SZ0]};

    reg [3:0] nbits;
    always @* begin
        if (size == `URX_SZ_NINE) begin
            nbits = `URX_SZ_NINE_BITS;
        end else if (size[2]) begin
            nbits = `URX_SZ_EIGHT;
        end else begin
            nbits = `URX_SZ_BASE + {2'b00, size[1:0]};
        end
    end

    wire [4:0] v1 = double_speed_reg ? `URX_D_V1 : `URX_N_V1;
    wire [4:0] v2 = double_speed_reg ? `URX_D_V2 : `URX_N_V2;
    wire [4:0] v3 = double_speed_reg ? `URX_D_V3 : `URX_N_V3;
    wire [4:0] last = double_speed_reg ? `URX_D_LAST : `URX_N_LAST;

    wire tick = (presc_reg == {BAUD_W{1'b0}});
    wire [4:0] samp_nx = (samp_reg == last) ? `URX_SAMP_FIRST :
                         samp_reg + 5'h01;
    wire rxd = serial_input_pin;
    wire maj = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & rxd) |
               (vote_reg[1] & rxd);
    wire xck_rise = transfer_clock_pin & ~xck_prev_reg;

    // one decided bit per bit period
    wire bit_evt = sync_mode ? xck_rise : (tick & (samp_nx == v3));
    wire bit_val = sync_mode ? rxd : maj;

    wire fifo_full = (count_reg == CNT_FULL);
    wire fifo_empty = (count_reg == {(PTR_W+1){1'b0}});
    wire push = pend_valid_reg & ~fifo_full;
    wire dat_rd = rd_en & (addr == `URX_ADDR_DAT);
    wire pop = dat_rd & ~fifo_empty;
    wire [11:0] head = fifo_mem[rd_ptr_reg];
    wire start_ok;
    wire enable = receive_enable_bit_reg;

    // start accepted: sync low on edge, or async centre majority low
    assign start_ok = sync_mode ?
                      (state_reg == ST_IDLE && xck_rise && !rxd) :
                      (state_reg == ST_START && bit_evt && !bit_val);

    // register writes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            double_speed_reg <= `URX_RST_STA;
            rx_irq_en_reg <= 1'b0;
            receive_enable_bit_reg <= 1'b0;
            size_hi_reg <= 1'b0;
            transmit_ninth_bit_reg <= 1'b0;
            cfg_c_reg <= `URX_RST_CFC;
            baud_reg <= `URX_RST_BAUD;
        end else if (wr_en) begin
            case (addr)
                `URX_ADDR_STA: begin
                    double_speed_reg <= wdata[`URX_STA_DSPD];
                end
                `URX_ADDR_CTB: begin
                    rx_irq_en_reg <= wdata[`URX_CTB_RECEIVE_COMPLETE_IRQ_ENABLE];
                    receive_enable_bit_reg <= wdata[`URX_CTB_RECEIVE_ENABLE_BIT];
                    size_hi_reg <= wdata[`URX_CTB_SZ2];
                    transmit_ninth_bit_reg <= wdata[`URX_CTB_TX9];
                end
                `URX_ADDR_CFC: begin
                    cfg_c_reg <= wdata;
                end
                `URX_ADDR_BAUD: begin
                    baud_reg <= wdata[BAUD_W-1:0];
                end
                default: begin
                    cfg_c_reg <= cfg_c_reg;
                end
            endcase
        end
    end

    // sample-rate prescaler and edge detect
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= {BAUD_W{1'b0}};
            xck_prev_reg <= 1'b0;
        end else begin
            xck_prev_reg <= transfer_clock_pin;
            if (!enable || tick) begin
                presc_reg <= baud_reg;
            end else begin
                presc_reg <= presc_reg - {{(BAUD_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // receive state machine
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            samp_reg <= 5'h00;
            vote_reg <= 2'b00;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 9'h000;
            par_acc_reg <= 1'b0;
            par_err_reg <= 1'b0;
            pend_valid_reg <= 1'b0;
            pend_data_reg <= 9'h000;
            pend_fe_reg <= 1'b0;
            pend_pe_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else if (!enable) begin
            state_reg <= ST_IDLE;
            samp_reg <= 5'h00;
            pend_valid_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            if (tick) begin
                samp_reg <= samp_nx;
                if (samp_nx == v1) begin
                    vote_reg[0] <= rxd;
                end
                if (samp_nx == v2) begin
                    vote_reg[1] <= rxd;
                end
            end
            if (push) begin
                pend_valid_reg <= 1'b0;
                overrun_reg <= 1'b0;
            end
            if (start_ok && pend_valid_reg && fifo_full) begin
                overrun_reg <= 1'b1;
                pend_valid_reg <= 1'b0;
            end
            if (start_ok) begin
                state_reg <= ST_DATA;
                bit_cnt_reg <= 4'h0;
                shift_reg <= 9'h000;
                par_acc_reg <= 1'b0;
                par_err_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (!sync_mode && tick && !rxd) begin
                            state_reg <= ST_START;
                            samp_reg <= `URX_SAMP_FIRST;
                        end
                    end
                    ST_START: begin
                        if (bit_evt) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_DATA: begin
                        if (bit_evt) begin
                            shift_reg[bit_cnt_reg] <= bit_val;
                            par_acc_reg <= par_acc_reg ^ bit_val;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == nbits - 4'h1) begin
                                state_reg <= par_on ? ST_PAR : ST_STOP;
                            end
                        end
                    end
                    ST_PAR: begin
                        if (bit_evt) begin
                            // even when low, odd when high
                            par_err_reg <= par_acc_reg ^ bit_val ^ par_odd;
                            state_reg <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (bit_evt) begin
                            state_reg <= ST_IDLE;
                            pend_valid_reg <= 1'b1;
                            pend_data_reg <= shift_reg;
                            pend_fe_reg <= ~bit_val;
                            pend_pe_reg <= par_on & par_err_reg;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // receive buffer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {PTR_W{1'b0}};
            rd_ptr_reg <= {PTR_W{1'b0}};
            count_reg <= {(PTR_W+1){1'b0}};
        end else if (!enable) begin
            wr_ptr_reg <= {PTR_W{1'b0}};
            rd_ptr_reg <= {PTR_W{1'b0}};
            count_reg <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + CNT_ONE[PTR_W-1:0];
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + CNT_ONE[PTR_W-1:0];
            end
            if (push && !pop) begin
                count_reg <= count_reg + CNT_ONE;
            end else if (pop && !push) begin
                count_reg <= count_reg - CNT_ONE;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    fifo_mem[gi] <= 12'h000;
                end else if (push && wr_ptr_reg == gi) begin
                    fifo_mem[gi] <= {pend_data_reg, pend_fe_reg,
                                     overrun_reg, pend_pe_reg};
                end
            end
        end
    endgenerate

    // read data, answered one cycle after the strobe
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        case (addr)
            `URX_ADDR_STA: begin
                rd_mux[`URX_STA_RXC] = ~fifo_empty;
                rd_mux[`URX_STA_FE] = ~fifo_empty & head[`URX_ENT_FE];
                rd_mux[`URX_STA_DOR] = ~fifo_empty & head[`URX_ENT_DOR];
                rd_mux[`URX_STA_PE] = ~fifo_empty & head[`URX_ENT_PE] &
                                      par_on;
                rd_mux[`URX_STA_DSPD] = double_speed_reg;
            end
            `URX_ADDR_CTB: begin
                rd_mux[`URX_CTB_RECEIVE_COMPLETE_IRQ_ENABLE] = rx_irq_en_reg;
                rd_mux[`URX_CTB_RECEIVE_ENABLE_BIT] = receive_enable_bit_reg;
                rd_mux[`URX_CTB_SZ2] = size_hi_reg;
                rd_mux[`URX_CTB_RX9] = ~fifo_empty & head[`URX_ENT_B8];
                rd_mux[`URX_CTB_TX9] = transmit_ninth_bit_reg;
            end
            `URX_ADDR_CFC: begin
                rd_mux = cfg_c_reg;
            end
            `URX_ADDR_DAT: begin
                rd_mux = fifo_empty ? 8'h00 :
                         head[`URX_ENT_DHI:`URX_ENT_DLO];
            end
            `URX_ADDR_BAUD: begin
                rd_mux[BAUD_W-1:0] = baud_reg;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            pin_override_reg <= 1'b0;
            rx_complete_irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rd_en ? rd_mux : 8'h00;
            pin_override_reg <= enable;
            rx_complete_irq_reg <= rx_irq_en_reg & enable &
                                   (push | (~fifo_empty &
                                    ~(pop && count_reg ==
                                      {{PTR_W{1'b0}}, 1'b1})));
        end
    end

endmodule // urx_receiver

// file: urx_receiver_sva.sv
`timescale 1ns/1ps
`include "urx_defs.vh"
module urx_receiver_sva (
    input wire clk,
    input wire rst_n,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rdata_reg,
    input wire serial_input_pin,
    input wire transfer_clock_pin,
    input wire pin_override_reg,
    input wire rx_complete_irq_reg
);
    reg ie_reg;
    reg en_reg;
    reg pe_reg;
    reg sz2_reg;
    reg [1:0] sz_reg;
    // shadow of the control fields the checks depend on
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_reg <= 1'b0;
            en_reg <= 1'b0;
            sz2_reg <= 1'b0;
            pe_reg <= 1'b0;
            sz_reg <= 2'h3;
        end else if (wr_en && addr == `URX_ADDR_CTB) begin
            ie_reg <= wdata[`URX_CTB_RECEIVE_COMPLETE_IRQ_ENABLE];
            en_reg <= wdata[`URX_CTB_RECEIVE_ENABLE_BIT];
            sz2_reg <= wdata[`URX_CTB_SZ2];
        end else if (wr_en && addr == `URX_ADDR_CFC) begin
            pe_reg <= wdata[`URX_CFC_UPM1];
            sz_reg <= wdata[2:1];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence ctb_wr_s;
        wr_en && addr == `URX_ADDR_CTB;
    endsequence
    sequence rd_sta_s;
        rd_en && addr == `URX_ADDR_STA;
    endsequence
    sequence rd_dat_s;
        rd_en && addr == `URX_ADDR_DAT;
    endsequence
    pin_take_a: assert property (
        ctb_wr_s |-> ##2 pin_override_reg == $past(wdata[`URX_CTB_RECEIVE_ENABLE_BIT], 2))
        else $error("pin ownership does not follow receive enable");
    irq_enable_a: assert property (
        rx_complete_irq_reg |-> ie_reg || $past(ie_reg))
        else $error("interrupt request without enable");
    flag_irq_a: assert property (
        rd_sta_s ##0 (ie_reg && $past(ie_reg))
        |=> rdata_reg[`URX_STA_RXC] == $past(rx_complete_irq_reg))
        else $error("complete flag and interrupt request disagree");
    off_data_a: assert property (
        rd_dat_s ##0 (!en_reg && !$past(en_reg)) |=> rdata_reg == 8'h00)
        else $error("data read while disabled is not zero");
    off_status_a: assert property (
        rd_sta_s ##0 (!en_reg && !$past(en_reg)) |=> rdata_reg[7:2] == 6'h00)
        else $error("status flags set while disabled");
    off_irq_a: assert property (
        ctb_wr_s ##0 !wdata[`URX_CTB_RECEIVE_ENABLE_BIT] |-> ##2 !rx_complete_irq_reg [*3])
        else $error("interrupt request kept after disable");
    par_off_a: assert property (
        rd_sta_s ##0 (!pe_reg && !$past(pe_reg)) |=> !rdata_reg[`URX_STA_PE])
        else $error("parity error shown with checking off");
    size_mask_a: assert property (
        rd_dat_s ##0 ({sz2_reg, sz_reg} == 3'h0) |=> rdata_reg[7:5] == 3'h0)
        else $error("unused data bits not zero");
    unmapped_rd_a: assert property (
        rd_en && addr > `URX_ADDR_BAUD |=> rdata_reg == 8'h00)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (!$past(rd_en) |-> rdata_reg == 8'h00)
        else $error("read data outside its cycle");
endmodule // urx_receiver_sva

// file: urx_tx_model.sv
`timescale 1ns/1ps
module urx_tx_model (
    input wire clk,
    output reg line,
    output reg xck
);
    initial begin
        line = 1'b1;
        xck = 1'b0;
    end
    // bits lsb first, no stop bit added, idle high after
    task send(input [11:0] bits, input integer n, input integer per,
              input integer sync);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clk);
                line <= bits[i];
                if (sync != 0) begin
                    // bit clock runs only within frames
                    repeat (2) @(posedge clk);
                    xck <= 1'b1;
                    repeat (3) @(posedge clk);
                    xck <= 1'b0;
                    repeat (2) @(posedge clk);
                end else begin
                    repeat (per - 1) @(posedge clk);
                end
            end
            @(posedge clk);
            line <= 1'b1;
        end
    endtask
endmodule // urx_tx_model

// file: urx_receiver_tb_top.sv
`timescale 1ns/1ps
`include "urx_defs.vh"
module urx_receiver_tb_top;
    reg clk, rst_n, wr_en, rd_en;
    reg [2:0] addr;
    reg [7:0] wdata, rv;
    wire [7:0] rdata_reg;
    wire rx_line, xck, pin_override_reg, rx_complete_irq_reg;
    integer fails, samples_checked, i;
    urx_receiver i_urx_receiver (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_reg(rdata_reg),
        .serial_input_pin(rx_line), .transfer_clock_pin(xck),
        .pin_override_reg(pin_override_reg),
        .rx_complete_irq_reg(rx_complete_irq_reg));
    urx_tx_model i_urx_tx_model (.clk(clk), .line(rx_line), .xck(xck));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input string nm, input [7:0] seen, input [7:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk);
            wr_en <= 1'b1;
            addr <= a;
            wdata <= d;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask
    task rchk(input [2:0] a, input [7:0] e);
        begin
            @(posedge clk);
            rd_en <= 1'b1;
            addr <= a;
            @(posedge clk);
            rd_en <= 1'b0;
            #1 rv = rdata_reg;
            chk($sformatf("reg%0d", a), rv, e);
        end
    endtask
    // pb below zero sends no parity bit
    task snd(input [8:0] d, input integer nd, input integer pb,
             input stp, input integer sync, input integer per);
        reg [11:0] f;
        integer k;
        begin
            f = 12'hFFE;
            for (k = 0; k < nd; k = k + 1)
                f[k + 1] = d[k];
            k = nd + 1;
            if (pb >= 0) begin
                f[k] = pb[0];
                k = k + 1;
            end
            f[k] = stp;
            i_urx_tx_model.send(f, k + 1, per, sync);
            #1;
        end
    endtask
    initial begin
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        fails = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk(`URX_ADDR_STA, 8'h00);
        rchk(`URX_ADDR_CTB, 8'h00);
        rchk(`URX_ADDR_CFC, 8'h06);
        rchk(`URX_ADDR_BAUD, 8'h00);
        rchk(3'h5, 8'h00);
        wr(`URX_ADDR_CTB, 8'h90);
        @(posedge clk);
        #1 chk("override", {7'h00, pin_override_reg}, 8'h01);
        i_urx_tx_model.send(12'hFFE, 1, 4, 0);
        repeat (40) @(posedge clk);
        rchk(`URX_ADDR_STA, 8'h00);
        snd(9'h0A5, 8, -1, 1'b1, 0, 16);
        chk("irq", {7'h00, rx_complete_irq_reg}, 8'h01);
        rchk(`URX_ADDR_STA, 8'h80);
        rchk(`URX_ADDR_DAT, 8'hA5);
        chk("irq", {7'h00, rx_complete_irq_reg}, 8'h00);
        wr(`URX_ADDR_STA, 8'h1E);
        wr(`URX_ADDR_CFC, 8'h08);
        rchk(`URX_ADDR_STA, 8'h02);
        snd(9'h01F, 5, -1, 1'b0, 0, 8);
        rchk(`URX_ADDR_STA, 8'h92);
        rchk(`URX_ADDR_DAT, 8'h1F);
        wr(`URX_ADDR_STA, 8'h00);
        for (i = 0; i < 2; i = i + 1) begin
            wr(`URX_ADDR_CFC, (i == 1) ? 8'h36 : 8'h26);
            snd(9'h0C3, 8, 1 - i, 1'b1, 0, 16);
            snd(9'h0C3, 8, i, 1'b1, 0, 16);
            rchk(`URX_ADDR_STA, 8'h84);
            rchk(`URX_ADDR_DAT, 8'hC3);
            rchk(`URX_ADDR_STA, 8'h80);
            rchk(`URX_ADDR_DAT, 8'hC3);
        end
        snd(9'h0C3, 8, 0, 1'b1, 0, 16);
        wr(`URX_ADDR_CFC, 8'h06);
        rchk(`URX_ADDR_STA, 8'h80);
        rchk(`URX_ADDR_DAT, 8'hC3);
        wr(`URX_ADDR_CTB, 8'h94);
        snd(9'h15A, 9, -1, 1'b1, 0, 16);
        rchk(`URX_ADDR_CTB, 8'h96);
        rchk(`URX_ADDR_DAT, 8'h5A);
        wr(`URX_ADDR_CTB, 8'h90);
        for (i = 0; i < 4; i = i + 1)
            snd(9'h030 + i[8:0], 8, -1, 1'b1, 0, 16);
        for (i = 0; i < 3; i = i + 1) begin
            rchk(`URX_ADDR_STA, (i == 2) ? 8'h88 : 8'h80);
            rchk(`URX_ADDR_DAT, (i == 2) ? 8'h33 : 8'h30 + i[7:0]);
        end
        snd(9'h044, 8, -1, 1'b1, 0, 16);
        rchk(`URX_ADDR_STA, 8'h80);
        rchk(`URX_ADDR_DAT, 8'h44);
        rchk(`URX_ADDR_STA, 8'h00);
        wr(`URX_ADDR_CFC, 8'h46);
        snd(9'h096, 8, -1, 1'b1, 1, 0);
        rchk(`URX_ADDR_DAT, 8'h96);
        wr(`URX_ADDR_CFC, 8'h06);
        // slower sample ticks: one tick every two clocks
        wr(`URX_ADDR_BAUD, 8'h01);
        snd(9'h0B4, 8, -1, 1'b1, 0, 32);
        rchk(`URX_ADDR_BAUD, 8'h01);
        rchk(`URX_ADDR_DAT, 8'hB4);
        wr(`URX_ADDR_BAUD, 8'h00);
        snd(9'h055, 8, -1, 1'b1, 0, 16);
        fork
            snd(9'h0AA, 8, -1, 1'b1, 0, 16);
            begin
                repeat (50) @(posedge clk);
                wr(`URX_ADDR_CTB, 8'h80);
            end
        join
        chk("override", {7'h00, pin_override_reg}, 8'h00);
        chk("irq", {7'h00, rx_complete_irq_reg}, 8'h00);
        rchk(`URX_ADDR_STA, 8'h00);
        rchk(`URX_ADDR_DAT, 8'h00);
        wr(`URX_ADDR_CTB, 8'h90);
        rchk(`URX_ADDR_STA, 8'h00);
        rchk(`URX_ADDR_DAT, 8'h00);
        stop_test;
    end
    initial begin
        #100000;
        fails = fails + 1;
        stop_test;
    end
endmodule // urx_receiver_tb_top
bind urx_receiver urx_receiver_sva i_urx_receiver_sva (.clk(clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_reg(rdata_reg),
    .serial_input_pin(serial_input_pin),
    .transfer_clock_pin(transfer_clock_pin),
    .pin_override_reg(pin_override_reg),
    .rx_complete_irq_reg(rx_complete_irq_reg));
